// ### pkg/dsb_pkg.sv
// constants and carrier types for the drive stop and brake sequencer
package dsb_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ----------------------------------------------------------------------
  // settings in tenths (time in 0.1 s ticks, percent in 0.1 %)
  // ----------------------------------------------------------------------
  localparam logic [10:0] THRESH_MAX = 11'h3E8;
  localparam logic [10:0] THRESH_RST = 11'h00A;
  localparam logic [10:0] HOLD_MAX = 11'h7D0;
  localparam logic [10:0] HOLD_RST = 11'h00A;
  localparam logic [10:0] BRAKE_MAX = 11'h7D0;
  localparam logic [10:0] BRAKE_RST = 11'h064;
  localparam logic [10:0] DEMAG_MIN = 11'h001;
  localparam logic [10:0] DEMAG_MAX = 11'h12C;
  localparam logic [10:0] DEMAG_RST = 11'h032;
  // gain in hundredths, integral time in ms
  localparam logic [10:0] GAIN_MAX = 11'h3E8;
  localparam logic [10:0] GAIN_RST = 11'h064;
  localparam logic [10:0] ITIME_MAX = 11'h3E8;
  localparam logic [10:0] ITIME_RST = 11'h032;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DSB_RUN = 3'b000,
    DSB_DECEL = 3'b001,
    DSB_DEMAG = 3'b011,
    DSB_BRAKE = 3'b010,
    DSB_HOLD = 3'b110,
    DSB_OFF = 3'b111,
    DSB_KEEP = 3'b101
  } dsb_state_t;

  typedef struct packed {
    logic [10:0] thresh;
    logic [10:0] hold;
    logic [10:0] brake;
    logic [10:0] demag;
    logic [10:0] gain;
    logic [10:0] itime;
  } dsb_cfg_t;

  typedef struct packed {
    logic brake_on;
    logic power_on;
    logic standstill;
    logic accel;
    logic p_en;
    logic i_en;
  } dsb_out_t;

endpackage : dsb_pkg

// ### hw/dsb_sequencer.sv
// stop, dc brake and auto start sequencer
`timescale 1ns/1ps
module dsb_sequencer
  import dsb_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned FW = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // drive state
  input wire logic [FW-1:0] out_freq_i,
  input wire logic [FW-1:0] max_freq_i,
  input wire logic [FW-1:0] nom_current_i,
  input wire logic mains_ok_i,
  input wire logic search_brake_i,
  // operator control
  input wire logic enable_input_a_i,
  input wire logic enable_input_b_i,
  input wire logic start_cw_i,
  input wire logic start_acw_i,
  // configuration
  input wire logic [2:0] stop_mode_i,
  input wire logic auto_start_i,
  input wire logic cfg_we_i,
  input wire dsb_cfg_t cfg_i,
  input wire logic [FW-1:0] brake_cur_i,
  input wire logic brake_cur_we_i,
  // status and drive
  output dsb_out_t stat_o,
  output dsb_cfg_t cfg_o,
  output logic [FW-1:0] brake_cur_o,
  output dsb_state_t state_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [10:0] clip(input logic [10:0] v,
                                       input logic [10:0] lo,
                                       input logic [10:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clip

  // root two approximated as 181/128, enough for a setpoint ceiling
  function automatic logic [FW-1:0] cur_max(input logic [FW-1:0] n);
    logic [FW+7:0] p;
    p = {8'h00, n} * (FW+8)'(181);
    cur_max = p[FW+6:7];
  endfunction : cur_max

  // ----------------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------------
  dsb_cfg_t cfg;
  logic [FW-1:0] brake_cur;
  logic [FW-1:0] i_lim;
  assign i_lim = cur_max(nom_current_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= '{THRESH_RST, HOLD_RST, BRAKE_RST, DEMAG_RST, GAIN_RST,
               ITIME_RST};
    end else if (cfg_we_i) begin
      cfg.thresh <= clip(cfg_i.thresh, 11'h000, THRESH_MAX);
      cfg.hold <= clip(cfg_i.hold, 11'h000, HOLD_MAX);
      cfg.brake <= clip(cfg_i.brake, 11'h000, BRAKE_MAX);
      cfg.demag <= clip(cfg_i.demag, DEMAG_MIN, DEMAG_MAX);
      cfg.gain <= clip(cfg_i.gain, 11'h000, GAIN_MAX);
      cfg.itime <= clip(cfg_i.itime, 11'h000, ITIME_MAX);
    end
  end

  // default to ceiling: the first cycle after reset loads it
  logic cur_init;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      brake_cur <= '0;
      cur_init <= 1'b1;
    end else begin
      cur_init <= 1'b0;
      if (cur_init) begin
        brake_cur <= i_lim;
      end else if (brake_cur_we_i) begin
        brake_cur <= (brake_cur_i > i_lim) ? i_lim : brake_cur_i;
      end else if (brake_cur > i_lim) begin
        brake_cur <= i_lim;
      end
    end
  end

  // ----------------------------------------------------------------------
  // standstill and start detection
  // ----------------------------------------------------------------------
  logic [FW+9:0] f_scaled;
  logic [FW+9:0] f_limit;
  logic standstill;
  assign f_scaled = {10'h000, out_freq_i} * (FW+10)'(1000);
  assign f_limit = {10'h000, max_freq_i} * {{(FW-1){1'b0}}, cfg.thresh};
  assign standstill = f_scaled < f_limit;

  logic ctrl_en;
  logic start_cmd;
  logic run_req;
  logic run_req_q;
  logic mains_q;
  logic armed;
  assign ctrl_en = enable_input_a_i & enable_input_b_i;
  assign start_cmd = start_cw_i | start_acw_i;
  assign run_req = ctrl_en & start_cmd;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_req_q <= 1'b0;
      mains_q <= 1'b0;
      armed <= 1'b0;
    end else begin
      run_req_q <= run_req;
      mains_q <= mains_ok_i;
      if (!mains_ok_i) begin
        armed <= 1'b0;
      end else if (!mains_q) begin
        armed <= auto_start_i | ~run_req;
      end else if (!run_req) begin
        armed <= 1'b1;
      end
    end
  end

  logic start_edge;
  logic go;
  assign start_edge = run_req & ~run_req_q;
  assign go = mains_ok_i & run_req & armed;

  // ----------------------------------------------------------------------
  // 0.1 s tick
  // ----------------------------------------------------------------------
  logic [31:0] div;
  logic tick;
  assign tick = div == TICK_LEN - 1;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div <= '0;
    end else begin
      div <= tick ? 32'h0000_0000 : div + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // stop sequencer
  // ----------------------------------------------------------------------
  dsb_state_t state;
  dsb_state_t next_state;
  logic [10:0] timer;
  logic [10:0] next_timer;
  logic has_brake;
  logic has_hold;
  logic contact;
  assign has_brake = stop_mode_i inside {3'd3, 3'd6, 3'd7};
  assign has_hold = stop_mode_i inside {3'd1, 3'd3, 3'd4, 3'd6};
  assign contact = cfg.brake == 11'h000;

  // a timed brake runs out its time even if a start arrives meanwhile
  logic restart;
  assign restart = go & ~(state == DSB_BRAKE & ~contact);

  always_comb begin
    next_state = state;
    next_timer = (tick && timer != 11'h000) ? timer - 11'h001 : timer;
    if (restart) begin
      next_state = DSB_RUN;
      next_timer = 11'h000;
    end else begin
      unique case (state)
        DSB_RUN: begin
          if (stop_mode_i == 3'd0) begin
            next_state = DSB_OFF;
          end else if (stop_mode_i == 3'd7) begin
            next_state = DSB_BRAKE;
            next_timer = cfg.brake;
          end else begin
            next_state = DSB_DECEL;
          end
        end
        DSB_DECEL: begin
          if (standstill) begin
            if (has_brake) begin
              next_state = DSB_DEMAG;
              next_timer = cfg.demag;
            end else if (has_hold) begin
              next_state = DSB_HOLD;
              next_timer = cfg.hold;
            end else begin
              next_state = DSB_KEEP;
            end
          end
        end
        DSB_DEMAG: begin
          if (timer == 11'h000) begin
            next_state = DSB_BRAKE;
            next_timer = cfg.brake;
          end
        end
        DSB_BRAKE: begin
          // time mode ignores the start inputs entirely
          if (contact ? !ctrl_en : timer == 11'h000) begin
            next_state = has_hold ? DSB_HOLD : DSB_OFF;
            next_timer = cfg.hold;
          end
        end
        DSB_HOLD: begin
          if (timer == 11'h000) begin
            next_state = DSB_OFF;
          end
        end
        DSB_OFF: next_state = DSB_OFF;
        DSB_KEEP: next_state = DSB_KEEP;
        default: next_state = DSB_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= DSB_OFF;
      timer <= 11'h000;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_o <= '0;
    end else begin
      stat_o.brake_on <= (next_state == DSB_BRAKE) | search_brake_i;
      stat_o.power_on <= next_state != DSB_OFF;
      stat_o.standstill <= standstill;
      stat_o.accel <= next_state == DSB_RUN;
      stat_o.p_en <= cfg.gain != 11'h000;
      stat_o.i_en <= cfg.itime != 11'h000;
    end
  end

  assign cfg_o = cfg;
  assign brake_cur_o = brake_cur;
  assign state_o = state;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_brake_modes: assert property (
    state == DSB_BRAKE |-> stop_mode_i inside {3'd3, 3'd6, 3'd7})
    else $error("brake in a mode without dc brake");
  a_demag_first: assert property (
    $rose(state == DSB_BRAKE) && !restart |->
    $past(state) == DSB_RUN || $past(timer) == 11'h000)
    else $error("brake entered before demagnetizing elapsed");
  a_timed_full: assert property (
    state == DSB_BRAKE && !contact && timer != 11'h000 |=>
    state == DSB_BRAKE)
    else $error("timed brake left early");
  a_contact_end: assert property (
    state == DSB_BRAKE && contact && ctrl_en && !restart |=>
    state == DSB_BRAKE)
    else $error("contact brake ended while enabled");
  a_contact_stop: assert property (
    state == DSB_BRAKE && contact && !ctrl_en |=> state != DSB_BRAKE)
    else $error("contact brake held after enable dropped");
  a_hold_off: assert property (
    state == DSB_HOLD && timer == 11'h000 && !restart |=>
    state == DSB_OFF && !stat_o.power_on)
    else $error("hold expiry did not switch off");
  a_hold_modes: assert property (
    state == DSB_HOLD |-> has_hold)
    else $error("holding time in a mode without it");
  a_off_dark: assert property (
    state == DSB_OFF |-> !stat_o.power_on)
    else $error("power stage on while switched off");
  a_start_clear: assert property (
    restart |=> state == DSB_RUN && timer == 11'h000)
    else $error("start did not clear the sequence");
  a_no_auto: assert property (
    !auto_start_i && mains_ok_i && !mains_q && run_req |=> !armed)
    else $error("edge mode armed on a held start");
  a_auto_lvl: assert property (
    auto_start_i && $rose(mains_ok_i) && run_req ##1
    run_req && mains_ok_i |-> go)
    else $error("level mode did not start");
  a_cur_lim: assert property (##1 brake_cur <= i_lim || $changed(i_lim))
    else $error("braking current above ceiling");

  c_timed: cover property (state == DSB_BRAKE && !contact ##1
    state == DSB_HOLD);
  c_contact: cover property (state == DSB_BRAKE && contact ##1
    state != DSB_BRAKE);
  c_auto: cover property (auto_start_i && go && !run_req_q);
  c_hold: cover property (state == DSB_HOLD ##1 state == DSB_OFF);
  c_held_brake: cover property (start_edge && go && !restart);

endmodule : dsb_sequencer

// ### dv/dsb_operator.sv
// operator control model: enable pair, start commands and mains supply
`timescale 1ns/1ps
module dsb_operator (
  // commands from the bench
  input wire logic run_i,
  input wire logic dir_i,
  input wire logic en_a_i,
  input wire logic en_b_i,
  input wire logic mains_i,
  // operator lines towards the sequencer
  output logic enable_input_a_o,
  output logic enable_input_b_o,
  output logic start_cw_o,
  output logic start_acw_o,
  output logic mains_ok_o
);
  // a run request is one start line only, never both directions at once
  assign enable_input_a_o = en_a_i;
  assign enable_input_b_o = en_b_i;
  assign start_cw_o = run_i & ~dir_i;
  assign start_acw_o = run_i & dir_i;
  assign mains_ok_o = mains_i;
endmodule : dsb_operator

// ### dv/tb_top.sv
// self-checking bench for the stop, brake and auto start sequencer
`timescale 1ns/1ps
module tb_top;
  import dsb_pkg::*;
  // short tick keeps every delay a few cycles long
  localparam int TL = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic run = 1'b0, dir = 1'b0, en_a = 1'b1, en_b = 1'b1, mains = 1'b1;
  logic srch = 1'b0, ast = 1'b0, cwe = 1'b0, bwe = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [15:0] ofreq = 16'h0000, nom = 16'h0100, bcur = 16'h0000;
  logic [15:0] bco;
  logic [15:0] ceil16;
  dsb_cfg_t cfg_in = '0;
  dsb_cfg_t cfg_o;
  dsb_out_t stat;
  dsb_state_t st;
  logic ea, eb, scw, sacw, mok;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h4E5F4403;

  always #25 clk_i = ~clk_i;

  dsb_operator op (.run_i(run), .dir_i(dir), .en_a_i(en_a), .en_b_i(en_b),
    .mains_i(mains), .enable_input_a_o(ea), .enable_input_b_o(eb),
    .start_cw_o(scw), .start_acw_o(sacw), .mains_ok_o(mok));

  dsb_sequencer #(.TICK_LEN(TL), .FW(16)) dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .out_freq_i(ofreq), .max_freq_i(16'h03E8),
    .nom_current_i(nom), .mains_ok_i(mok), .search_brake_i(srch),
    .enable_input_a_i(ea), .enable_input_b_i(eb), .start_cw_i(scw),
    .start_acw_i(sacw), .stop_mode_i(mode), .auto_start_i(ast),
    .cfg_we_i(cwe), .cfg_i(cfg_in), .brake_cur_i(bcur),
    .brake_cur_we_i(bwe), .stat_o(stat), .cfg_o(cfg_o), .brake_cur_o(bco),
    .state_o(st));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [10:0] clip(logic [10:0] v, logic [10:0] lo,
                                       logic [10:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clip

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(string nm, logic [65:0] e, logic [65:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic rng(string nm, int v, int lo, int hi);
    cmp_count++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : rng

  task automatic wait_st(dsb_state_t s, int lim);
    for (int n = 0; n < lim && st !== s; n++) @(negedge clk_i);
    chk("state", s, st);
    if (st !== s) test_done();
  endtask : wait_st

  // --------------------------------------------------------------------
  // one start and stop in mode m, braking time b ticks (0 = contact)
  // --------------------------------------------------------------------
  task automatic stop_run(logic [2:0] m, int b);
    int h, d, th, t_on, t_off, t_pw;
    h = 2 + rnd() % 3;
    d = 2 + rnd() % 3;
    th = 1 + rnd() % 50;
    cfg_in = '{11'(th), 11'(h), 11'(b), 11'(d), GAIN_RST, ITIME_RST};
    mode = m;
    cwe = 1'b1;
    @(negedge clk_i);
    cwe = 1'b0;
    ofreq = 16'(th);
    dir = rnd() % 2;
    run = 1'b1;
    wait_st(DSB_RUN, 8);
    chk("power_on", 1'b1, stat.power_on);
    chk("accel", 1'b1, stat.accel);
    run = 1'b0;
    t_on = -1;
    t_off = -1;
    t_pw = -1;
    for (int c = 0; c < 140; c++) begin
      @(negedge clk_i);
      if (c == 10) ofreq = 16'(th - 1);
      if (c == 100 && b == 0) en_a = 1'b0;
      if (c == 5) chk("standstill", 1'b0, stat.standstill);
      if (stat.brake_on === 1'b1 && t_on < 0) t_on = c;
      // one start pulse inside a timed brake must not cut it short
      if (b != 0) run = (c == t_on);
      if (stat.brake_on !== 1'b1 && t_on >= 0 && t_off < 0) t_off = c;
      if (stat.power_on !== 1'b1 && t_pw < 0) t_pw = c;
    end
    en_a = 1'b1;
    chk("standstill", 1'b1, stat.standstill);
    chk("accel", 1'b0, stat.accel);
    chk("brake_used", (m == 3 || m == 6 || m == 7), t_on >= 0);
    if (m == 7) rng("brake_delay", t_on, 0, 1);
    if (m == 3 || m == 6) rng("demag", t_on - 10, (d-1)*TL, (d+1)*TL+2);
    if (b != 0 && t_on >= 0) rng("brake_len", t_off - t_on, (b-1)*TL, (b+1)*TL+2);
    if (b == 0) rng("contact_end", t_off, 100, 102);
    case (m)
      3'h0: rng("off_delay", t_pw, 0, 1);
      3'h1, 3'h4: rng("hold", t_pw - 10, (h-1)*TL, (h+1)*TL+2);
      3'h3, 3'h6: rng("hold", t_pw - t_off, (h-1)*TL, (h+1)*TL+2);
      3'h7: rng("off_delay", t_pw - t_off, 0, 1);
      default: chk("keep", DSB_KEEP, st);
    endcase
  endtask : stop_run

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    nom = 16'(rnd() % 16'h4000);
    ceil16 = 16'((32'(nom) * 181) >> 7);
    repeat (12) @(negedge clk_i);
    chk("stat_rst", '0, stat);
    chk("state_rst", DSB_OFF, st);
    chk("cfg_rst", {THRESH_RST, HOLD_RST, BRAKE_RST, DEMAG_RST, GAIN_RST,
        ITIME_RST}, cfg_o);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("brake_cur", ceil16, bco);
    for (int i = 0; i < 8; i++) begin
      cfg_in = (i == 0) ? '0 : ((i == 1) ? '1 : 66'({rnd(), rnd(), 2'b00}));
      bcur = (i == 0) ? 16'h0000 : ((i == 1) ? 16'hFFFF : 16'(rnd()));
      cwe = 1'b1;
      bwe = 1'b1;
      @(negedge clk_i);
      cwe = 1'b0;
      bwe = 1'b0;
      chk("cfg", {clip(cfg_in.thresh, 11'h000, THRESH_MAX),
          clip(cfg_in.hold, 11'h000, HOLD_MAX),
          clip(cfg_in.brake, 11'h000, BRAKE_MAX),
          clip(cfg_in.demag, DEMAG_MIN, DEMAG_MAX),
          clip(cfg_in.gain, 11'h000, GAIN_MAX),
          clip(cfg_in.itime, 11'h000, ITIME_MAX)}, cfg_o);
      chk("brake_cur", (bcur > ceil16) ? ceil16 : bcur, bco);
      @(negedge clk_i);
      chk("p_en", cfg_in.gain != 11'h000, stat.p_en);
      chk("i_en", cfg_in.itime != 11'h000, stat.i_en);
    end
    srch = 1'b1;
    @(negedge clk_i);
    chk("search_brake", 1'b1, stat.brake_on);
    srch = 1'b0;
    for (int m = 0; m < 8; m++) stop_run(3'(m), 2 + rnd() % 4);
    stop_run(3'h3, 0);
    // free stop keeps each auto start round short
    mode = 3'h0;
    for (int a = 0; a < 2; a++) begin
      ast = 1'(a);
      mains = 1'b0;
      run = 1'b1;
      repeat (3) @(negedge clk_i);
      mains = 1'b1;
      repeat (5) @(negedge clk_i);
      chk("auto_start", a ? DSB_RUN : DSB_OFF, st);
      run = 1'b0;
      repeat (2) @(negedge clk_i);
      run = 1'b1;
      wait_st(DSB_RUN, 8);
      run = 1'b0;
      wait_st(DSB_OFF, 8);
    end
    for (int k = 0; k < 6; k++) stop_run(3'(rnd()), 1 + rnd() % 5);
    test_done();
  end
endmodule : tb_top
